// ### spl_ctrl_model.sv
// Controller model that drives the pin side of the shift latch.
`timescale 1ns/10ps

module spl_ctrl_model (
    output logic shift_clock,
    output logic serial_in,
    output logic shift_clear_n,
    output logic storage_clock,
    output logic storage_clear_n
);
    localparam int HALF_NS = 15;

    // Link clocks stand still low between frames; clears start released.
    initial
    begin
        shift_clock = 1'b0;
        storage_clock = 1'b0;
        serial_in = 1'b0;
        shift_clear_n = 1'b1;
        storage_clear_n = 1'b1;
    end

    // One shift pulse, optionally with the storage clock tied to it.
    // Data is inverted after the fall so a stale level is never trusted.
    task automatic pulse(input logic d, input logic tie);
        serial_in = d;
        #HALF_NS;
        shift_clock = 1'b1;
        storage_clock = tie;
        #HALF_NS;
        shift_clock = 1'b0;
        storage_clock = 1'b0;
        serial_in = ~d;
    endtask

    // A lone storage pulse, with the shift clock held low.
    task automatic store();
        storage_clock = 1'b1;
        #HALF_NS;
        storage_clock = 1'b0;
        #HALF_NS;
    endtask

    // Clear levels are held until the next call.
    task automatic set_clears(input logic sh_n, input logic st_n);
        shift_clear_n = sh_n;
        storage_clear_n = st_n;
        #HALF_NS;
    endtask
endmodule // spl_ctrl_model

// ### spl_pair_buf.sv
// Small valid/ready buffer used to hand captured storage words to the core.
`timescale 1ns/10ps

module spl_pair_buf #(
    parameter int WIDTH = spl_pkg::SPL_WIDTH,
    parameter int DEPTH = spl_pkg::SPL_BUF_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import spl_pkg::*;

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] FULL_CNT = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] entry_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    wire push;
    wire pop;
    wire [PTR_W-1:0] wr_ptr_next;
    wire [PTR_W-1:0] rd_ptr_next;

    // ------------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------------
    // Full and empty come straight from the occupancy count.
    assign in_ready = (count_reg != FULL_CNT);
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign wr_ptr_next = (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
    assign rd_ptr_next = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
    assign out_data = entry_reg[rd_ptr_reg];

    // ------------------------------------------------------------------
    // Storage entries
    // ------------------------------------------------------------------
    // Each entry only loads when the write pointer selects it.
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        always_ff @(posedge clk)
        begin
            if (srst)
                entry_reg[i] <= '0;
            else if (ce && push && (wr_ptr_reg == PTR_W'(i)))
                entry_reg[i] <= in_data;
        end
    end

    // Pointers and count move together so full and empty never disagree.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else if (ce)
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_next;
            if (pop)
                rd_ptr_reg <= rd_ptr_next;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end

endmodule // spl_pair_buf

// ### spl_pkg.sv
// Shared constants for the serial-in, parallel-out shift latch.
package spl_pkg;

    // ------------------------------------------------------------------
    // Data path shape
    // ------------------------------------------------------------------
    localparam int SPL_WIDTH = 8;
    localparam int SPL_BUF_DEPTH = 2;

    // ------------------------------------------------------------------
    // Reset and power-up values
    // ------------------------------------------------------------------
    localparam logic [SPL_WIDTH-1:0] SPL_WORD_ZERO = 8'h00;
    localparam logic SPL_BIT_LOW = 1'b0;

    // ------------------------------------------------------------------
    // Field positions inside a shift word
    // ------------------------------------------------------------------
    localparam int SPL_FIRST_STAGE = 0;
    localparam int SPL_LAST_STAGE = SPL_WIDTH - 1;

    // Width of the helper counter that tracks shift edges since a clear.
    localparam int SPL_LAG_W = $clog2(SPL_WIDTH + 1);

endpackage : spl_pkg

// ### spl_shift_latch.sv
// Serial-in, parallel-out shift register with storage register and core-side word stream.
`timescale 1ns/10ps

// What this block does
// R1 - Eight shift stages feed an eight-bit storage register driving parallel outputs.
// R2 - Both clocks act only on rising edges; otherwise contents hold.
// R3 - With clocks tied, storage always lags the shift register by one pulse.
// R4 - Low shift clear forces all shift stages low at once.
// R5 - Low storage clear forces storage bits and parallel outputs low at once.
// R6 - Cascade output always shows the last shift stage, bypassing storage.
// R7 - Shift edge loads serial input into stage one and moves others along.
// R8 - Storage edge alone copies all shift stages; shift stages keep values.
// R9 - Both edges together: storage takes pre-edge shift contents, then shift advances.
// R10 - Every shift stage and storage bit powers up low.
// R11 - Low storage clear wins over serial input, both clocks and shift clear.
// R12 - Controller keeps serial data stable at edges and stores whenever the bench calls for it, after one bit or eight.
// R13 - While a clear is low its register ignores its clock edges.
module spl_shift_latch (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic shift_clear_n,
    input wire logic storage_clock,
    input wire logic storage_clear_n,
    output logic [spl_pkg::SPL_WIDTH-1:0] parallel_out,
    output logic cascade_out,
    output logic word_valid,
    input wire logic word_ready,
    output logic [spl_pkg::SPL_WIDTH-1:0] word_data,
    output logic word_overrun,
    input wire logic overrun_clear
);
    import spl_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Initial values model the power-on state of both registers.
    logic [SPL_WIDTH-1:0] shift_reg = SPL_WORD_ZERO; // see R10
    logic [SPL_WIDTH-1:0] storage_reg = SPL_WORD_ZERO; // see R10
    logic store_tgl_reg = SPL_BIT_LOW;
    logic shift_tgl_reg = SPL_BIT_LOW;
    logic [SPL_LAG_W-1:0] lag_cnt_reg = '0;
    logic store_sync1_reg;
    logic store_sync2_reg;
    logic store_seen_reg;
    logic pend_valid_reg;
    logic [SPL_WIDTH-1:0] pend_data_reg;
    logic overrun_reg;
    wire [SPL_WIDTH-1:0] shift_next;
    wire store_event;
    wire pend_taken;
    wire pend_blocked;
    wire buf_in_ready;
    wire [SPL_LAG_W-1:0] lag_cnt_next;

    localparam logic [SPL_LAG_W-1:0] LAG_FULL = SPL_LAG_W'(SPL_WIDTH);

    // ------------------------------------------------------------------
    // Shift register, clocked by the link's shift clock
    // ------------------------------------------------------------------
    // Stage zero takes the serial bit; every stage above takes its neighbour.
    assign shift_next = {shift_reg[SPL_LAST_STAGE-1:SPL_FIRST_STAGE], serial_in}; // see R7

    // The clear is asynchronous so it acts even with the shift clock stopped.
    always_ff @(posedge shift_clock or negedge shift_clear_n)
    begin
        if (!shift_clear_n)
            shift_reg <= SPL_WORD_ZERO; // see R4 see R13
        else
            shift_reg <= shift_next; // see R2 see R7
    end

    // The cascade pin taps the last stage directly, never the storage copy.
    assign cascade_out = shift_reg[SPL_LAST_STAGE]; // see R6

    // Edge toggle and saturating edge count, read only by the checks below.
    // The count saturates so that it never wraps back into the lag window.
    assign lag_cnt_next = (lag_cnt_reg == LAG_FULL) ? lag_cnt_reg : lag_cnt_reg + 1'b1;

    always_ff @(posedge shift_clock or negedge shift_clear_n)
    begin
        if (!shift_clear_n)
        begin
            shift_tgl_reg <= SPL_BIT_LOW;
            lag_cnt_reg <= '0;
        end
        else
        begin
            shift_tgl_reg <= !shift_tgl_reg;
            lag_cnt_reg <= lag_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Storage register, clocked by the storage clock
    // ------------------------------------------------------------------
    // Non-blocking capture takes the shift word as it stood before any
    // shift edge in the same instant, which gives the one-pulse lag when
    // both clocks are tied. The shift word is not resynchronised here on
    // purpose: the parts are meant to be one coherent pair of registers.
    always_ff @(posedge storage_clock or negedge storage_clear_n)
    begin
        if (!storage_clear_n)
        begin
            storage_reg <= SPL_WORD_ZERO; // see R5 see R11 see R13
            store_tgl_reg <= SPL_BIT_LOW;
        end
        else
        begin
            storage_reg <= shift_reg; // see R1 see R8 see R9 see R3
            store_tgl_reg <= !store_tgl_reg;
        end
    end

    // Parallel pins follow the storage register only.
    assign parallel_out = storage_reg; // see R1

    // ------------------------------------------------------------------
    // Crossing of store events into the core clock
    // ------------------------------------------------------------------
    // The toggle is the request; the word itself is quiet between storage
    // edges, so it is sampled once the toggle has passed two flops.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            store_sync1_reg <= SPL_BIT_LOW;
            store_sync2_reg <= SPL_BIT_LOW;
            store_seen_reg <= SPL_BIT_LOW;
        end
        else if (ce)
        begin
            store_sync1_reg <= store_tgl_reg;
            store_sync2_reg <= store_sync1_reg;
            store_seen_reg <= store_sync2_reg;
        end
    end

    // Limitation: storage edges closer than about one core cycle can fold
    // into one toggle change, so a word may then be lost without an overrun.
    assign store_event = ce && (store_sync2_reg != store_seen_reg);

    // ------------------------------------------------------------------
    // Pending word and overrun flag
    // ------------------------------------------------------------------
    // A word waits here while the buffer is full; a newer word replaces it,
    // which keeps the freshest output state at the cost of an overrun.
    assign pend_taken = pend_valid_reg && buf_in_ready;
    assign pend_blocked = pend_valid_reg && !buf_in_ready;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pend_valid_reg <= SPL_BIT_LOW;
            pend_data_reg <= SPL_WORD_ZERO;
        end
        else if (store_event)
        begin
            pend_valid_reg <= 1'b1;
            pend_data_reg <= storage_reg;
        end
        else if (ce && pend_taken)
            pend_valid_reg <= SPL_BIT_LOW;
    end

    // A new overrun in the clearing cycle keeps the flag set.
    always_ff @(posedge core_clk)
    begin
        if (srst)
            overrun_reg <= SPL_BIT_LOW;
        else if (store_event && pend_blocked)
            overrun_reg <= 1'b1;
        else if (ce && overrun_clear)
            overrun_reg <= SPL_BIT_LOW;
    end

    assign word_overrun = overrun_reg;

    // ------------------------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------------------------
    // A receiver stall fills the buffer, which then holds the pending word.
    spl_pair_buf #(
        .WIDTH(SPL_WIDTH),
        .DEPTH(SPL_BUF_DEPTH)
    ) u_pair_buf (
        .clk(core_clk),
        .srst(srst),
        .ce(ce),
        .in_valid(pend_valid_reg),
        .in_ready(buf_in_ready),
        .in_data(pend_data_reg),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Pin registers are watched from the core clock as well: the link is far
    // slower, so every pin edge falls between two core samples.
    // Each shift edge moves the word up by one and takes the serial bit.
    property p_shift_advance;
        @(posedge shift_clock) disable iff (!shift_clear_n)
        1'b1 |=> (shift_reg == {$past(shift_reg[SPL_LAST_STAGE-1:SPL_FIRST_STAGE]),
                                $past(serial_in)});
    endproperty
    AST_SHIFT_ADVANCE: assert property (p_shift_advance) // see R7
        else $error("Shift register did not advance by one stage.");

    // Eight edges after a clear the cascade pin shows the bit from eight edges back.
    property p_cascade_lag;
        @(posedge shift_clock) disable iff (!shift_clear_n)
        (lag_cnt_reg == LAG_FULL) |-> (cascade_out == $past(serial_in, SPL_WIDTH));
    endproperty
    AST_CASCADE_LAG: assert property (p_cascade_lag) // see R6
        else $error("Cascade output does not match serial input eight edges back.");

    // A low shift clear holds every stage low whatever the clock does.
    AST_SHIFT_CLEAR: assert property ( // see R4 see R13
        @(posedge core_clk) disable iff (srst)
        !shift_clear_n |-> (shift_reg == SPL_WORD_ZERO && !cascade_out))
        else $error("Shift stages not low while shift clear is low.");

    // A low storage clear holds the parallel pins low.
    AST_STORE_CLEAR: assert property ( // see R5 see R11
        @(posedge core_clk) disable iff (srst)
        !storage_clear_n |-> (parallel_out == SPL_WORD_ZERO))
        else $error("Parallel outputs not low while storage clear is low.");

    // Without a shift edge or a clear the shift word cannot move.
    AST_SHIFT_QUIET: assert property ( // see R2
        @(posedge core_clk) disable iff (srst)
        ($stable(shift_tgl_reg) && shift_clear_n && $past(shift_clear_n))
        |-> $stable(shift_reg))
        else $error("Shift register changed without a rising shift edge.");

    // Without a storage edge or a clear the parallel pins cannot move.
    AST_STORE_QUIET: assert property ( // see R2 see R8
        @(posedge core_clk) disable iff (srst)
        ($stable(store_tgl_reg) && storage_clear_n && $past(storage_clear_n))
        |-> $stable(parallel_out))
        else $error("Parallel outputs changed without a rising storage edge.");

    // A storage edge alone leaves the shift word untouched.
    AST_STORE_NO_SHIFT: assert property ( // see R8
        @(posedge core_clk) disable iff (srst)
        ($changed(store_tgl_reg) && $stable(shift_tgl_reg) && shift_clear_n
            && $past(shift_clear_n)) |-> $stable(shift_reg))
        else $error("Storage edge disturbed the shift register.");

    // A detected store event reaches the pending slot in the next core cycle.
    sequence s_store_seen;
        store_event;
    endsequence
    sequence s_pending_loaded;
        pend_valid_reg && (pend_data_reg == $past(storage_reg));
    endsequence
    AST_EVENT_CAPTURE: assert property ( // see R1
        @(posedge core_clk) disable iff (srst)
        s_store_seen |=> s_pending_loaded)
        else $error("Captured storage word not loaded into pending slot.");

    // A stalled word stays put until the receiver accepts it.
    AST_WORD_HOLD: assert property (
        @(posedge core_clk) disable iff (srst)
        (word_valid && !word_ready && ce) |=> (word_valid && $stable(word_data)))
        else $error("Output word dropped or changed while stalled.");

    // An overrun always comes from a store event meeting a blocked pending word.
    AST_OVERRUN_CAUSE: assert property (
        @(posedge core_clk) disable iff (srst)
        $rose(overrun_reg) |-> $past(store_event && pend_blocked))
        else $error("Overrun flag set without a blocked store event.");

    // A clear with the core running drops the flag unless a new overrun arrives.
    AST_OVERRUN_CLEAR: assert property (
        @(posedge core_clk) disable iff (srst)
        (ce && overrun_clear && !(store_event && pend_blocked)) |=> !overrun_reg)
        else $error("Overrun flag not cleared.");

    // A storage edge loads the shift word as it stood just before the edge,
    // whether or not a shift edge fell in the same instant; with both clocks
    // tied this is what keeps storage one pulse behind.
    sequence s_store_edge;
        $changed(store_tgl_reg) && storage_clear_n && $past(storage_clear_n);
    endsequence
    sequence s_shift_open;
        shift_clear_n && $past(shift_clear_n);
    endsequence
    AST_STORE_PRE_EDGE: assert property ( // see R9 see R3
        @(posedge core_clk) disable iff (srst)
        (s_store_edge and s_shift_open) |-> (parallel_out == $past(shift_reg)))
        else $error("Storage did not take the pre-edge shift word.");

    // While a clear stays low, clock edges on its register leave no trace.
    AST_STORE_CLEAR_EDGE: assert property ( // see R13
        @(posedge core_clk) disable iff (srst)
        (!storage_clear_n && !$past(storage_clear_n)) |-> $stable(store_tgl_reg))
        else $error("Storage edge acted while storage clear was low.");

    AST_SHIFT_CLEAR_EDGE: assert property ( // see R13
        @(posedge core_clk) disable iff (srst)
        (!shift_clear_n && !$past(shift_clear_n)) |-> $stable(shift_tgl_reg))
        else $error("Shift edge acted while shift clear was low.");

    // ------------------------------------------------------------------
    // Core stream checks
    // ------------------------------------------------------------------
    // The flag is sticky until a clear is taken with the core running.
    AST_OVERRUN_STICKY: assert property (
        @(posedge core_clk) disable iff (srst)
        (overrun_reg && !(ce && overrun_clear)) |=> overrun_reg)
        else $error("Overrun flag dropped without a clear.");

    // A replaced pending word always raises the flag, even during a clear.
    AST_OVERRUN_SET_WINS: assert property (
        @(posedge core_clk) disable iff (srst)
        (store_event && pend_blocked) |=> overrun_reg)
        else $error("Replaced pending word did not raise the overrun flag.");

    // A blocked pending word waits unchanged while no newer word arrives.
    AST_PEND_HOLD: assert property (
        @(posedge core_clk) disable iff (srst)
        (pend_blocked && !store_event) |=> (pend_valid_reg && $stable(pend_data_reg)))
        else $error("Blocked pending word was lost or changed.");

    // A pending word taken by the buffer leaves the stream valid one cycle later.
    AST_PEND_TO_BUF: assert property (
        @(posedge core_clk) disable iff (srst)
        (ce && pend_taken) |=> word_valid)
        else $error("Word taken by the buffer did not appear on the stream.");

endmodule // spl_shift_latch

// ### spl_shift_latch_bench.sv
// Self-checking bench for the shift latch with its core word stream.
`timescale 1ns/10ps

module spl_shift_latch_bench;
    import spl_pkg::*;

    // ------------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------------
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic word_ready = 1'b0;
    logic overrun_clear = 1'b0;
    logic stall = 1'b1;
    logic shift_clock, serial_in, shift_clear_n, storage_clock, storage_clear_n;
    logic [SPL_WIDTH-1:0] parallel_out, word_data, sh, st;
    logic cascade_out, word_valid, word_overrun;
    logic tog = 1'b0;
    logic [31:0] seed = 32'hc3d40968;
    logic [SPL_WIDTH-1:0] exp_q[$];
    int err_count = 0;
    int num_checks = 0;

    spl_ctrl_model i_ctrl (.shift_clock(shift_clock), .serial_in(serial_in),
        .shift_clear_n(shift_clear_n), .storage_clock(storage_clock),
        .storage_clear_n(storage_clear_n));

    spl_shift_latch i_dut (.core_clk(core_clk), .srst(srst), .ce(ce),
        .shift_clock(shift_clock), .serial_in(serial_in), .shift_clear_n(shift_clear_n),
        .storage_clock(storage_clock), .storage_clear_n(storage_clear_n),
        .parallel_out(parallel_out), .cascade_out(cascade_out), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data), .word_overrun(word_overrun),
        .overrun_clear(overrun_clear));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Core clock at 200 MHz.
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end

    function automatic logic [7:0] rnd8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic check_pin(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_word(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Every accepted storage edge becomes one word on the stream unless an overrun replaces it while pending.
    task automatic push(input logic [7:0] w);
        exp_q.push_back(w);
        tog = ~tog;
    endtask

    // Shift a byte most significant bit first, so it lands as written.
    task automatic send(input logic [7:0] b, input logic tie);
        for (int i = 7; i >= 0; i--)
        begin
            if (tie)
            begin
                st = sh;
                push(st);
            end
            sh = {sh[6:0], b[i]};
            i_ctrl.pulse(b[i], tie);
            check_pin({7'h00, cascade_out}, {7'h00, sh[7]});
            check_pin(parallel_out, st);
        end
    endtask

    task automatic store_word();
        st = sh;
        push(st);
        i_ctrl.store();
        check_pin(parallel_out, st);
        check_pin({7'h00, cascade_out}, {7'h00, sh[7]});
    endtask

    task automatic drain();
        for (int k = 0; k < 400 && exp_q.size() != 0; k++)
            @(negedge core_clk);
        check_pin(8'(exp_q.size()), 8'h00);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Receiver ready: random, about three cycles in four, unless stalled.
    always @(negedge core_clk)
    begin
        word_ready <= stall ? 1'b0 : (rnd8() & 8'h03) != 8'h00;
    end

    // Stream monitor: each accepted word is matched with the oldest note.
    always @(posedge core_clk)
    begin
        if (!srst && ce && word_valid === 1'b1 && word_ready)
        begin
            if (exp_q.size() != 0)
                check_word(word_data, exp_q.pop_front());
            else
            begin
                err_count++;
                $display("MISMATCH at %0t: got %h expected %h", $time, word_data, 8'h00);
            end
        end
    end

    // Watchdog cuts a hang short; the run normally ends well before it.
    initial
    begin
        #100us;
        err_count++;
        $display("MISMATCH at %0t: got %h expected %h", $time, 8'h01, 8'h00);
        give_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        sh = 8'h00;
        st = 8'h00;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk) srst = 1'b0;
        repeat (3) @(negedge core_clk);
        check_pin(parallel_out, 8'h00);
        check_pin({7'h00, cascade_out}, 8'h00);
        check_pin({7'h00, word_overrun}, 8'h00);
        stall = 1'b0;
        // Offsets the link pulses from the core clock so they never share an edge.
        #1.3;
        $display("test power_up done");
        repeat (4)
        begin
            send(rnd8(), 1'b0);
            store_word();
        end
        $display("test split_clocks done");
        send(rnd8(), 1'b1);
        send(8'ha5, 1'b1);
        $display("test tied_clocks done");
        i_ctrl.set_clears(1'b0, 1'b1);
        sh = 8'h00;
        check_pin({7'h00, cascade_out}, 8'h00);
        i_ctrl.pulse(1'b1, 1'b0);
        check_pin({7'h00, cascade_out}, 8'h00);
        i_ctrl.set_clears(1'b1, 1'b1);
        store_word();
        send(8'hff, 1'b0);
        store_word();
        // A storage clear with the toggle up yields one all-zero word; note it first.
        st = 8'h00;
        if (tog)
            push(8'h00);
        i_ctrl.set_clears(1'b1, 1'b0);
        check_pin(parallel_out, 8'h00);
        i_ctrl.pulse(1'b1, 1'b1);
        sh = {sh[6:0], 1'b1};
        i_ctrl.store();
        check_pin(parallel_out, 8'h00);
        i_ctrl.set_clears(1'b1, 1'b1);
        check_pin(parallel_out, 8'h00);
        check_pin({7'h00, cascade_out}, {7'h00, sh[7]});
        $display("test clears done");
        drain();
        @(negedge core_clk) stall = 1'b1;
        #1.3;
        repeat (4)
        begin
            send(rnd8(), 1'b0);
            store_word();
        end
        exp_q.delete(exp_q.size() - 2);
        repeat (8) @(negedge core_clk);
        check_pin({7'h00, word_overrun}, 8'h01);
        ce = 1'b0;
        stall = 1'b0;
        overrun_clear = 1'b1;
        repeat (10) @(negedge core_clk);
        overrun_clear = 1'b0;
        check_pin({7'h00, word_overrun}, 8'h01);
        ce = 1'b1;
        overrun_clear = 1'b1;
        @(negedge core_clk) overrun_clear = 1'b0;
        check_pin({7'h00, word_overrun}, 8'h00);
        drain();
        $display("test overrun done");
        give_verdict();
    end
endmodule // spl_shift_latch_bench
